// ### verilog/mbk_port_bank.sv
// Five-port I/O bank with APB register access
// What this block does
// - Five ports, one to five, thirty-three pins in total.
// - Ports two to five have per-pin direction registers.
// - Port one is a 6-bit latch, no direction; reads return pins.
// - Processor memory modes turn ports three to five into system bus.
// - Enabled PWM or USART takes its pins over automatically.
// - Cleared direction bit drives pin; peripheral sees the driven level.
// - USART controls output enables of port one pins four and five.
// - Port one pin one carries the first timer's clock input.
// - Port one pins two, three open-drain: 0 pulls low, 1 floats.
// - Port one writes affect only the open-drain pins' drive.
// - Port read returns pin levels; write stores into output latch.
// - Bit ops read pins and write all bits back to latch.
// - Write takes effect at cycle end; read samples at cycle start.
`timescale 1ns/1ns
`include "mbk_params.svh"
module mbk_port_bank
  import mbk_pkg::*;
#(
  parameter mbk_mode_t RESET_MODE = MBK_MODE_MCU
) (
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST_B,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [7:0]             PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic [`MBK_W_ONE-1:0]  PORT_ONE_IN,
  output logic      [`MBK_W_ONE-1:0]  PORT_ONE_OUT,
  output logic      [`MBK_W_ONE-1:0]  PORT_ONE_OE,
  input  wire logic [`MBK_W_WIDE-1:0] PORT_TWO_IN,
  output logic      [`MBK_W_WIDE-1:0] PORT_TWO_OUT,
  output logic      [`MBK_W_WIDE-1:0] PORT_TWO_OE,
  input  wire logic [`MBK_W_WIDE-1:0] PORT_THREE_IN,
  output logic      [`MBK_W_WIDE-1:0] PORT_THREE_OUT,
  output logic      [`MBK_W_WIDE-1:0] PORT_THREE_OE,
  input  wire logic [`MBK_W_WIDE-1:0] PORT_FOUR_IN,
  output logic      [`MBK_W_WIDE-1:0] PORT_FOUR_OUT,
  output logic      [`MBK_W_WIDE-1:0] PORT_FOUR_OE,
  input  wire logic [`MBK_W_FIVE-1:0] PORT_FIVE_IN,
  output logic      [`MBK_W_FIVE-1:0] PORT_FIVE_OUT,
  output logic      [`MBK_W_FIVE-1:0] PORT_FIVE_OE,
  input  wire logic [1:0]             PWM_EN,
  input  wire logic [1:0]             PWM_OUT,
  input  wire logic                   USART_EN,
  input  wire logic [1:0]             USART_OUT,
  input  wire logic [1:0]             USART_OE,
  output logic      [1:0]             USART_PIN_IN,
  output logic                        FIRST_TIMER_CLK,
  output logic      [`MBK_W_WIDE-1:0] PORT_TWO_PERIPH_IN,
  input  wire logic [15:0]            BUS_AD_OUT,
  input  wire logic                   BUS_AD_OE,
  input  wire logic [`MBK_W_FIVE-1:0] BUS_CTL_OUT,
  input  wire logic                   BUS_CTL_OE,
  output logic      [15:0]            BUS_AD_IN,
  output logic                        BUS_MODE
);
  default clocking mbk_cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [`MBK_W_ALL-1:0]  pins_s;
  logic [`MBK_W_ONE-1:0]  one_s;
  logic [`MBK_W_WIDE-1:0] two_s;
  logic [`MBK_W_WIDE-1:0] three_s;
  logic [`MBK_W_WIDE-1:0] four_s;
  logic [`MBK_W_FIVE-1:0] five_s;

  mbk_sync #(.W(`MBK_W_ALL)) u_sync (
    .clk   (CLK_SYS),
    .rst_b (RST_B),
    .d     ({PORT_FIVE_IN, PORT_FOUR_IN, PORT_THREE_IN, PORT_TWO_IN, PORT_ONE_IN}),
    .q     (pins_s)
  );

  assign {five_s, four_s, three_s, two_s, one_s} = pins_s;

  // Pin levels include our own drive, so peripherals see what we output
  assign FIRST_TIMER_CLK     = one_s[`MBK_ONE_TMR_PIN];
  assign USART_PIN_IN        = one_s[`MBK_ONE_US_HI:`MBK_ONE_US_LO];
  assign PORT_TWO_PERIPH_IN  = two_s;
  assign BUS_AD_IN           = {four_s, three_s};

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic                   setup_ph;
  logic                   wr_acc;
  logic                   hit_one;
  logic                   hit_two;
  logic                   hit_dtwo;
  logic                   hit_three;
  logic                   hit_dthr;
  logic                   hit_four;
  logic                   hit_dfour;
  logic                   hit_five;
  logic                   hit_dfive;
  logic                   hit_mode;
  logic                   hit_any;
  logic [31:0]            rd_val;

  logic [`MBK_W_ONE-1:0]  lat_one_q;
  logic [`MBK_W_WIDE-1:0] lat_two_q;
  logic [`MBK_W_WIDE-1:0] lat_three_q;
  logic [`MBK_W_WIDE-1:0] lat_four_q;
  logic [`MBK_W_FIVE-1:0] lat_five_q;
  logic [`MBK_W_WIDE-1:0] dir_two_q;
  logic [`MBK_W_WIDE-1:0] dir_three_q;
  logic [`MBK_W_WIDE-1:0] dir_four_q;
  logic [`MBK_W_FIVE-1:0] dir_five_q;
  mbk_mode_t              mode_q;
  logic                   bus_mode;

  assign setup_ph  = PSEL && !PENABLE;
  assign wr_acc    = PSEL && PENABLE && PWRITE && PREADY;
  assign hit_one   = PADDR == `MBK_OFS_ONE;
  assign hit_two   = PADDR == `MBK_OFS_TWO;
  assign hit_dtwo  = PADDR == `MBK_OFS_DIR_TWO;
  assign hit_three = PADDR == `MBK_OFS_THREE;
  assign hit_dthr  = PADDR == `MBK_OFS_DIR_THR;
  assign hit_four  = PADDR == `MBK_OFS_FOUR;
  assign hit_dfour = PADDR == `MBK_OFS_DIR_FOUR;
  assign hit_five  = PADDR == `MBK_OFS_FIVE;
  assign hit_dfive = PADDR == `MBK_OFS_DIR_FIVE;
  assign hit_mode  = PADDR == `MBK_OFS_MODE;
  assign hit_any   = hit_one | hit_two | hit_dtwo | hit_three | hit_dthr | hit_four
                   | hit_dfour | hit_five | hit_dfive | hit_mode;

  // Port reads show pins, never latches; bit ops thus write pins back
  assign rd_val = hit_one   ? {26'h0, one_s} :
                  hit_two   ? {24'h0, two_s} :
                  hit_dtwo  ? {24'h0, dir_two_q} :
                  hit_three ? {24'h0, three_s} :
                  hit_dthr  ? {24'h0, dir_three_q} :
                  hit_four  ? {24'h0, four_s} :
                  hit_dfour ? {24'h0, dir_four_q} :
                  hit_five  ? {29'h0, five_s} :
                  hit_dfive ? {29'h0, dir_five_q} :
                  hit_mode  ? {30'h0, mode_q} : 32'h0;

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  // Pins sampled at the setup edge, i.e. the start of the access
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
      PREADY  <= 1'b0;
    end else begin
      PREADY <= 1'b1;
      if (setup_ph) begin
        PRDATA  <= PWRITE ? 32'h0 : rd_val;
        PSLVERR <= !hit_any;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Latches and direction registers
  // ----------------------------------------------------------------------
  // Writes land at the access edge, the end of the transfer
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      lat_one_q   <= `MBK_RST_LAT_ONE;
      lat_two_q   <= `MBK_RST_LAT;
      lat_three_q <= `MBK_RST_LAT;
      lat_four_q  <= `MBK_RST_LAT;
      lat_five_q  <= `MBK_RST_LAT_FIVE;
      dir_two_q   <= `MBK_RST_DIR;
      dir_three_q <= `MBK_RST_DIR;
      dir_four_q  <= `MBK_RST_DIR;
      dir_five_q  <= `MBK_RST_DIR_FIVE;
      mode_q      <= RESET_MODE;
    end else if (wr_acc) begin
      if (hit_one)   lat_one_q   <= PWDATA[`MBK_W_ONE-1:0];
      if (hit_two)   lat_two_q   <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_three) lat_three_q <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_four)  lat_four_q  <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_five)  lat_five_q  <= PWDATA[`MBK_W_FIVE-1:0];
      if (hit_dtwo)  dir_two_q   <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_dthr)  dir_three_q <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_dfour) dir_four_q  <= PWDATA[`MBK_W_WIDE-1:0];
      if (hit_dfive) dir_five_q  <= PWDATA[`MBK_W_FIVE-1:0];
      if (hit_mode)  mode_q      <= mbk_mode_t'(PWDATA[1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive selection
  // ----------------------------------------------------------------------
  logic [`MBK_W_ONE-1:0]  one_out_d;
  logic [`MBK_W_ONE-1:0]  one_oe_d;
  logic [`MBK_W_WIDE-1:0] two_out_d;
  logic [`MBK_W_WIDE-1:0] two_oe_d;
  logic [`MBK_W_WIDE-1:0] three_out_d;
  logic [`MBK_W_WIDE-1:0] three_oe_d;
  logic [`MBK_W_WIDE-1:0] four_out_d;
  logic [`MBK_W_WIDE-1:0] four_oe_d;
  logic [`MBK_W_FIVE-1:0] five_out_d;
  logic [`MBK_W_FIVE-1:0] five_oe_d;
  logic [1:0]             us_out;
  logic [1:0]             us_oe;
  logic [1:0]             od_oe;

  assign bus_mode = (mode_q == MBK_MODE_EXT) || (mode_q == MBK_MODE_PROC);

  // Latch drives only the open-drain pair; the rest follow USART or float
  assign us_out    = USART_EN ? USART_OUT : 2'h0;
  assign us_oe     = USART_EN ? USART_OE : 2'h0;
  assign od_oe     = ~lat_one_q[`MBK_ONE_OD_HI:`MBK_ONE_OD_LO];
  assign one_out_d = {us_out, 4'h0};
  assign one_oe_d  = {us_oe, od_oe, 2'h0};

  // PWM overrides whatever the direction bit holds
  assign two_out_d = {lat_two_q[7:4],
                      PWM_EN[1] ? PWM_OUT[1] : lat_two_q[`MBK_TWO_PWM_HI],
                      PWM_EN[0] ? PWM_OUT[0] : lat_two_q[`MBK_TWO_PWM_LO],
                      lat_two_q[1:0]};
  assign two_oe_d  = {~dir_two_q[7:4],
                      PWM_EN[1] | ~dir_two_q[`MBK_TWO_PWM_HI],
                      PWM_EN[0] | ~dir_two_q[`MBK_TWO_PWM_LO],
                      ~dir_two_q[1:0]};

  assign three_out_d = bus_mode ? BUS_AD_OUT[7:0] : lat_three_q;
  assign three_oe_d  = bus_mode ? {8{BUS_AD_OE}} : ~dir_three_q;
  assign four_out_d  = bus_mode ? BUS_AD_OUT[15:8] : lat_four_q;
  assign four_oe_d   = bus_mode ? {8{BUS_AD_OE}} : ~dir_four_q;
  assign five_out_d  = bus_mode ? BUS_CTL_OUT : lat_five_q;
  assign five_oe_d   = bus_mode ? {3{BUS_CTL_OE}} : ~dir_five_q;

  // Registered pin drive keeps outputs glitch free
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PORT_ONE_OUT   <= 6'h00;
      PORT_ONE_OE    <= 6'h00;
      PORT_TWO_OUT   <= 8'h00;
      PORT_TWO_OE    <= 8'h00;
      PORT_THREE_OUT <= 8'h00;
      PORT_THREE_OE  <= 8'h00;
      PORT_FOUR_OUT  <= 8'h00;
      PORT_FOUR_OE   <= 8'h00;
      PORT_FIVE_OUT  <= 3'h0;
      PORT_FIVE_OE   <= 3'h0;
      BUS_MODE       <= 1'b0;
    end else begin
      PORT_ONE_OUT   <= one_out_d;
      PORT_ONE_OE    <= one_oe_d;
      PORT_TWO_OUT   <= two_out_d;
      PORT_TWO_OE    <= two_oe_d;
      PORT_THREE_OUT <= three_out_d;
      PORT_THREE_OE  <= three_oe_d;
      PORT_FOUR_OUT  <= four_out_d;
      PORT_FOUR_OE   <= four_oe_d;
      PORT_FIVE_OUT  <= five_out_d;
      PORT_FIVE_OE   <= five_oe_d;
      BUS_MODE       <= bus_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  od_drive_a: assert property (
    !lat_one_q[`MBK_ONE_OD_LO] |=> PORT_ONE_OE[`MBK_ONE_OD_LO] && !PORT_ONE_OUT[`MBK_ONE_OD_LO])
    else $error("open-drain pin not pulled low");

  od_float_a: assert property (
    lat_one_q[`MBK_ONE_OD_HI] |=> !PORT_ONE_OE[`MBK_ONE_OD_HI] && PORT_ONE_OE[1:0] == 2'h0)
    else $error("port one drives a pin it should not");

  // Pin drive is judged against the latch one cycle back, so back to back writes hold
  wr_latch_a: assert property (
    wr_acc && hit_two |=> lat_two_q == $past(PWDATA[7:0])
      ##1 PORT_TWO_OUT[1:0] == $past(lat_two_q[1:0]))
    else $error("port two write not stored at access edge");

  rd_pins_a: assert property (
    setup_ph && !PWRITE && hit_two |=> PRDATA[7:0] == $past(two_s) && PREADY ##1 !$stable(PRDATA)
      || PRDATA[7:0] == $past(two_s, 2))
    else $error("port two read not from pin snapshot");

  dir_in_a: assert property (
    dir_two_q[0] |=> !PORT_TWO_OE[0])
    else $error("input pin still driven");

  dir_out_a: assert property (
    !dir_two_q[1] |=> PORT_TWO_OE[1] && PORT_TWO_OUT[1] == $past(lat_two_q[1]))
    else $error("output pin not driven from latch");

  bus_take_a: assert property (
    bus_mode |=> PORT_THREE_OE == {8{$past(BUS_AD_OE)}} && PORT_FIVE_OUT == $past(BUS_CTL_OUT)
      && BUS_MODE)
    else $error("system bus not on ports three to five");

  pwm_take_a: assert property (
    PWM_EN[0] |=> PORT_TWO_OE[`MBK_TWO_PWM_LO] && PORT_TWO_OUT[`MBK_TWO_PWM_LO] == $past(PWM_OUT[0]))
    else $error("PWM pin not taken over");

  usart_oe_a: assert property (
    USART_EN |=> PORT_ONE_OE[`MBK_ONE_US_HI:`MBK_ONE_US_LO] == $past(USART_OE))
    else $error("USART pin enables not followed");

  dir_reset_a: assert property (
    $rose(PREADY) |-> dir_two_q == 8'hFF && dir_five_q == 3'h7 && PORT_THREE_OE == 8'h00)
    else $error("direction not all inputs after reset");
endmodule

// ### shared/mbk_params.svh
// Constants for the multiplexed I/O port bank
`ifndef MBK_PARAMS_SVH
`define MBK_PARAMS_SVH

// ----------------------------------------------------------------------
// Port widths
// ----------------------------------------------------------------------
`define MBK_W_ONE        6
`define MBK_W_WIDE       8
`define MBK_W_FIVE       3
`define MBK_W_ALL        33

// ----------------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------------
`define MBK_ONE_TMR_PIN  1
`define MBK_ONE_OD_LO    2
`define MBK_ONE_OD_HI    3
`define MBK_ONE_US_LO    4
`define MBK_ONE_US_HI    5
`define MBK_TWO_PWM_LO   2
`define MBK_TWO_PWM_HI   3

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MBK_OFS_ONE      8'h00
`define MBK_OFS_TWO      8'h04
`define MBK_OFS_DIR_TWO  8'h08
`define MBK_OFS_THREE    8'h0C
`define MBK_OFS_DIR_THR  8'h10
`define MBK_OFS_FOUR     8'h14
`define MBK_OFS_DIR_FOUR 8'h18
`define MBK_OFS_FIVE     8'h1C
`define MBK_OFS_DIR_FIVE 8'h20
`define MBK_OFS_MODE     8'h24

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MBK_RST_LAT_ONE  6'h00
`define MBK_RST_LAT      8'h00
`define MBK_RST_LAT_FIVE 3'h0
`define MBK_RST_DIR      8'hFF
`define MBK_RST_DIR_FIVE 3'h7

`endif

// ### shared/mbk_pkg.sv
// Types for the multiplexed I/O port bank
package mbk_pkg;
  // Memory mode; the two processor-style modes own ports three to five
  typedef enum logic [1:0] {
    MBK_MODE_MCU  = 2'h0,
    MBK_MODE_EXT  = 2'h1,
    MBK_MODE_PROC = 2'h3,
    MBK_MODE_SEC  = 2'h2
  } mbk_mode_t;
endpackage

// ### verilog/mbk_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module mbk_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### tb/mbk_pin_model.sv
// Model of the board circuitry on the bank's pins
`timescale 1ns/1ns
module mbk_pin_model (
  input  wire logic        clk,
  input  wire logic [32:0] dev_out,
  input  wire logic [32:0] dev_oe,
  input  wire logic [32:0] ext_val,
  input  wire logic [32:0] ext_en,
  output logic      [32:0] pin
);
  // ----------------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------------
  // Pull-ups on port one pins 2 and 3 only
  localparam logic [32:0] PULL_UP = 33'h00000000C;
  logic [32:0] flt_q = 33'h000000000;
  // Floating pins change every cycle, so a stale level is never read as valid
  always_ff @(posedge clk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int i = 0; i < 33; i++) begin
      if (dev_oe[i] === 1'b1) begin
        pin[i] = dev_out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (PULL_UP[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flt_q[i];
      end
    end
  end
endmodule

// ### tb/mbk_port_bank_tb.sv
// Self-checking bench for the I/O port bank
`timescale 1ns/1ns
`include "mbk_params.svh"
module mbk_port_bank_tb
  import mbk_pkg::*;
;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, us_en, bus_ad_oe, bus_ctl_oe;
  logic        tmr_clk, bus_mode;
  logic [1:0]  pwm_en, pwm_out, us_out, us_oe, us_pin_in;
  logic [2:0]  bus_ctl_out;
  logic [7:0]  paddr, p2_periph;
  logic [15:0] bus_ad_out, bus_ad_in;
  logic [31:0] pwdata, prdata, rdat;
  logic [32:0] ext_val, ext_en;
  wire  logic [32:0] pin, dout, doe;
  int          fail_count, samples_checked;

  mbk_port_bank u_mbk_port_bank (
    .CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PORT_ONE_IN(pin[5:0]), .PORT_ONE_OUT(dout[5:0]), .PORT_ONE_OE(doe[5:0]),
    .PORT_TWO_IN(pin[13:6]), .PORT_TWO_OUT(dout[13:6]), .PORT_TWO_OE(doe[13:6]),
    .PORT_THREE_IN(pin[21:14]), .PORT_THREE_OUT(dout[21:14]), .PORT_THREE_OE(doe[21:14]),
    .PORT_FOUR_IN(pin[29:22]), .PORT_FOUR_OUT(dout[29:22]), .PORT_FOUR_OE(doe[29:22]),
    .PORT_FIVE_IN(pin[32:30]), .PORT_FIVE_OUT(dout[32:30]), .PORT_FIVE_OE(doe[32:30]),
    .PWM_EN(pwm_en), .PWM_OUT(pwm_out), .USART_EN(us_en), .USART_OUT(us_out),
    .USART_OE(us_oe), .USART_PIN_IN(us_pin_in), .FIRST_TIMER_CLK(tmr_clk),
    .PORT_TWO_PERIPH_IN(p2_periph), .BUS_AD_OUT(bus_ad_out), .BUS_AD_OE(bus_ad_oe),
    .BUS_CTL_OUT(bus_ctl_out), .BUS_CTL_OE(bus_ctl_oe), .BUS_AD_IN(bus_ad_in),
    .BUS_MODE(bus_mode));

  mbk_pin_model u_mbk_pin_model (
    .clk(clk), .dev_out(dout), .dev_oe(doe), .ext_val(ext_val), .ext_en(ext_en), .pin(pin));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Leaves the request standing, so a second transfer may follow at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      final_report();
    end else begin
      rdat = prdata;
      chk("slverr", 32'(a > `MBK_OFS_MODE), 32'(pslverr));
    end
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    idle();
    chk(nm, exp, rdat);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rd_chk("dir2", `MBK_OFS_DIR_TWO, 32'h000000FF);
    // Drive has settled by now; only the open-drain pair pulls low
    chk("oe_rst", 32'h0, 32'(doe[32:6]));
    chk("oe_od_rst", 32'h0000000C, 32'(doe[5:0]));
    rd_chk("dir3", `MBK_OFS_DIR_THR, 32'h000000FF);
    rd_chk("dir4", `MBK_OFS_DIR_FOUR, 32'h000000FF);
    rd_chk("dir5", `MBK_OFS_DIR_FIVE, 32'h00000007);
    rd_chk("unmap", 8'h28, 32'h0);
  endtask
  task automatic t_drive();
    logic [7:0] lo [4] = '{`MBK_OFS_TWO, `MBK_OFS_THREE, `MBK_OFS_FOUR, `MBK_OFS_FIVE};
    int         bit0 [4] = '{6, 14, 22, 30};
    int         wd [4] = '{8, 8, 8, 3};
    logic [31:0] m;
    for (int k = 0; k < 4; k++) begin
      m = (32'h1 << wd[k]) - 32'h1;
      wr_reg(lo[k] + 8'h04, 32'hFFFFFF00);
      rd_chk("dir_lo", lo[k] + 8'h04, 32'h0);
      wr_reg(lo[k], 32'h000000C5);
      repeat (4) @(posedge clk);
      chk("out", 32'h000000C5 & m, 32'((dout >> bit0[k]) & 33'(m)));
      chk("oe", m, 32'((doe >> bit0[k]) & 33'(m)));
      rd_chk("pin_rd", lo[k], 32'h000000C5 & m);
      wr_reg(lo[k] + 8'h04, m);
      ext_en <= 33'h1FFFFFFFF;
      ext_val <= 33'h0;
      repeat (4) @(posedge clk);
      chk("oe_in", 32'h0, 32'((doe >> bit0[k]) & 33'(m)));
      rd_chk("in_rd", lo[k], 32'h0);
      ext_en <= 33'h0;
    end
  endtask
  task automatic t_timing();
    wr_reg(`MBK_OFS_DIR_TWO, 32'h0);
    wr_reg(`MBK_OFS_TWO, 32'h00000011);
    repeat (4) @(posedge clk);
    apb(1'b1, `MBK_OFS_TWO, 32'h00000022);
    apb(1'b0, `MBK_OFS_TWO, 32'h0);
    idle();
    chk("rd_old", 32'h00000011, rdat);
    repeat (4) @(posedge clk);
    rd_chk("rd_new", `MBK_OFS_TWO, 32'h00000022);
  endtask
  task automatic t_rmw();
    wr_reg(`MBK_OFS_DIR_TWO, 32'h000000F0);
    wr_reg(`MBK_OFS_TWO, 32'h0);
    ext_en <= 33'h00003C00;
    ext_val <= 33'h00002800;
    repeat (4) @(posedge clk);
    rd_chk("rmw_rd", `MBK_OFS_TWO, 32'h000000A0);
    chk("periph_in", 32'h000000A0, 32'(p2_periph));
    wr_reg(`MBK_OFS_TWO, rdat | 32'h1);
    ext_en <= 33'h0;
    wr_reg(`MBK_OFS_DIR_TWO, 32'h0);
    repeat (4) @(posedge clk);
    chk("rmw_out", 32'h000000A1, 32'(dout[13:6]));
    chk("periph", 32'h000000A1, 32'(p2_periph));
  endtask
  task automatic t_one();
    wr_reg(`MBK_OFS_ONE, 32'h0);
    ext_en <= 33'h000000033;
    ext_val <= 33'h000000033;
    repeat (4) @(posedge clk);
    chk("oe1", 32'h0000000C, 32'(doe[5:0]));
    chk("out1", 32'h0, 32'(dout[3:2]));
    rd_chk("rd1", `MBK_OFS_ONE, 32'h00000033);
    chk("tmr", 32'h1, 32'(tmr_clk));
    wr_reg(`MBK_OFS_ONE, 32'h0000003F);
    repeat (4) @(posedge clk);
    chk("oe1_hi", 32'h0, 32'(doe[5:0]));
    rd_chk("rd1_up", `MBK_OFS_ONE, 32'h0000003F);
    ext_en <= 33'h0;
    us_en <= 1'b1;
    us_oe <= 2'h3;
    us_out <= 2'h2;
    repeat (4) @(posedge clk);
    chk("us_oe", 32'h3, 32'(doe[5:4]));
    chk("us_out", 32'h2, 32'(dout[5:4]));
    chk("us_in", 32'h2, 32'(us_pin_in));
    us_en <= 1'b0;
  endtask
  task automatic t_pwm();
    wr_reg(`MBK_OFS_DIR_TWO, 32'h000000FF);
    pwm_en <= 2'h1;
    pwm_out <= 2'h1;
    repeat (3) @(posedge clk);
    chk("pwm0", 32'h3, 32'({doe[8], dout[8]}));
    pwm_en <= 2'h3;
    pwm_out <= 2'h2;
    repeat (3) @(posedge clk);
    chk("pwm1", 32'hE, 32'({doe[9:8], dout[9:8]}));
    pwm_en <= 2'h0;
    wr_reg(`MBK_OFS_DIR_TWO, 32'h000000FF);
    repeat (3) @(posedge clk);
    chk("pwm_off", 32'h0, 32'(doe[13:6]));
  endtask
  task automatic t_mode();
    mbk_mode_t md [4] = '{MBK_MODE_MCU, MBK_MODE_EXT, MBK_MODE_PROC, MBK_MODE_SEC};
    logic      bm;
    bus_ad_oe <= 1'b1;
    bus_ctl_oe <= 1'b1;
    bus_ad_out <= 16'hBE5A;
    bus_ctl_out <= 3'h5;
    for (int k = 0; k < 4; k++) begin
      bm = (md[k] == MBK_MODE_EXT) || (md[k] == MBK_MODE_PROC);
      wr_reg(`MBK_OFS_MODE, 32'(md[k]));
      rd_chk("mode_rd", `MBK_OFS_MODE, 32'(md[k]));
      repeat (4) @(posedge clk);
      chk("bmode", 32'(bm), 32'(bus_mode));
      chk("bus_oe", bm ? 32'h0007FFFF : 32'h0, 32'(doe[32:14]));
      if (bm) begin
        chk("bus_out", 32'h0005BE5A, 32'(dout[32:14]));
        chk("bus_in", 32'h0000BE5A, 32'(bus_ad_in));
      end
    end
    wr_reg(`MBK_OFS_MODE, 32'h0);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, us_en, bus_ad_oe, bus_ctl_oe} = 6'h00;
    {pwm_en, pwm_out, us_out, us_oe} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    bus_ad_out = 16'h0000;
    bus_ctl_out = 3'h0;
    ext_val = 33'h0;
    ext_en = 33'h0;
    fail_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    chk("oe_in_rst", 32'h0, doe[31:0]);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset();
    t_drive();
    t_timing();
    t_rmw();
    t_one();
    t_pwm();
    t_mode();
    final_report();
  end
endmodule
